// [rtl/cpm_pkg.sv]
// package: constants of the core register file
`default_nettype none
package cpm_pkg;
    localparam logic [7:0]  DBG_RD_DATA0   = 8'h60;
    localparam logic [7:0]  DBG_WR_DATA0   = 8'h40;
    localparam logic [7:0]  DBG_RD_PC      = 8'hEF;
    localparam logic [7:0]  DBG_WR_PC      = 8'hCF;
    localparam logic [7:0]  DBG_RD_STATUS  = 8'hEE;
    localparam logic [7:0]  DBG_WR_STATUS  = 8'hCE;
    localparam logic [7:0]  DBG_RD_ISP     = 8'hE0;
    localparam logic [7:0]  DBG_WR_ISP     = 8'hC0;
    localparam logic [7:0]  DBG_RD_VBASE   = 8'hE1;
    localparam logic [7:0]  DBG_WR_VBASE   = 8'hC1;
    localparam logic [7:0]  DBG_RD_CFG     = 8'hE2;
    localparam logic [7:0]  DBG_WR_CFG     = 8'hC2;
    localparam logic [11:0] CTL_IDX_VBASE  = 12'h801;
    localparam logic [11:0] CTL_IDX_CFG    = 12'h802;
    localparam logic [31:0] RST_VEC_SP     = 32'h0000_0000;
    localparam logic [31:0] RST_VEC_PC     = 32'h0000_0004;
    localparam logic [15:0] STATUS_RESET   = 16'h2700;
    localparam logic [15:0] STATUS_MASK    = 16'hB71F;
    localparam logic [15:0] FLAGS_MASK     = 16'h001F;
    localparam logic [31:0] VBASE_MASK     = 32'h00F0_0000;
    localparam logic [31:0] CFG_RESET      = 32'h0000_0000;
    localparam int          BIT_TRACE      = 15;
    localparam int          BIT_PRIV       = 13;
    localparam int          BIT_MASTER     = 12;
    localparam int          BIT_EXT        = 4;
    localparam int          BIT_NEG        = 3;
    localparam int          BIT_ZERO       = 2;
    localparam int          BIT_OVF        = 1;
    localparam int          BIT_CARRY      = 0;
    localparam logic [2:0]  LEVEL_NMI      = 3'h7;
    typedef enum logic [1:0] {
        CPM_FETCH_SP = 2'b00,
        CPM_FETCH_PC = 2'b01,
        CPM_RUN      = 2'b11
    } cpm_state_t;
endpackage : cpm_pkg
`default_nettype wire

// [rtl/cpm_regfile.sv]
// core programming model register file with debug command access
// ----------------------------------------------------------------
// ----------------------------------------------------------------
`default_nettype none
module cpm_regfile #(
    parameter logic [31:0] HW_CFG0 = 32'h1234_5678, // arbitrary value
    parameter logic [31:0] HW_CFG1 = 32'h0000_0001  // arbitrary value
) (
    input  wire logic        ref_clk,
    input  wire logic        arst_n,
    // reset vector fetch
    output logic             vec_req,
    output logic [31:0]      vec_addr,
    input  wire logic        vec_ack,
    input  wire logic [31:0] vec_data,
    output logic             core_ready,
    // debug command port
    input  wire logic        dbg_valid,
    input  wire logic [7:0]  dbg_cmd,
    input  wire logic [31:0] dbg_wdata,
    output logic [31:0]      dbg_rdata,
    output logic             dbg_rvalid,
    output logic             dbg_err,
    // core register port
    input  wire logic        gpr_we,
    input  wire logic [3:0]  gpr_waddr,
    input  wire logic [31:0] gpr_wdata,
    input  wire logic [3:0]  gpr_raddr,
    output logic [31:0]      gpr_rdata,
    input  wire logic        pc_we,
    input  wire logic [31:0] pc_wdata,
    output logic [31:0]      program_counter,
    input  wire logic        status_we,
    input  wire logic [15:0] status_wdata,
    output logic [15:0]      status_word,
    input  wire logic        ctl_we,
    input  wire logic [11:0] ctl_idx,
    input  wire logic [31:0] ctl_wdata,
    input  wire logic        usp_to_reg,
    input  wire logic        reg_to_usp,
    input  wire logic [3:0]  usp_reg,
    output logic             priv_fault,
    // flag update from the arithmetic unit
    input  wire logic        flags_we,
    input  wire logic        arith_op,
    input  wire logic [31:0] result,
    input  wire logic        carry_out,
    input  wire logic        overflow,
    // exception support
    input  wire logic        irq_take,
    input  wire logic [2:0]  irq_level,
    input  wire logic        irq_edge7,
    output logic             irq_pending,
    output logic             trace_req,
    input  wire logic [31:0] vec_disp,
    output logic [31:0]      vec_fetch_addr,
    output logic [31:0]      vector_table_base,
    output logic [31:0]      core_configuration
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [31:0] gpr_reg [16];
    logic [31:0] gpr_next [16];
    logic [31:0] isp_reg, isp_next;
    logic [31:0] pc_reg, pc_next;
    logic [15:0] sr_reg, sr_next;
    logic [31:0] vbr_reg, vbr_next;
    logic [31:0] cfg_reg, cfg_next;
    logic [31:0] rd_reg, rd_next;
    logic        rv_reg, rv_next;
    logic        er_reg, er_next;
    cpm_pkg::cpm_state_t st_reg, st_next;

    logic        supv;
    logic        dbg_rd, dbg_wr;
    logic [3:0]  dbg_idx;
    assign supv    = sr_reg[cpm_pkg::BIT_PRIV];
    assign dbg_idx = dbg_cmd[3:0];
    // bit 5 tells read from write in every code pair
    assign dbg_rd  = dbg_valid && (dbg_cmd[7:4] == cpm_pkg::DBG_RD_DATA0[7:4]);
    assign dbg_wr  = dbg_valid && (dbg_cmd[7:4] == cpm_pkg::DBG_WR_DATA0[7:4]);

    // ------------------------------------------------------------
    // next values
    // ------------------------------------------------------------
    always_comb begin
        logic [15:0] sw;
        sw = 16'h0000;
        for (int i = 0; i < 16; i++) begin
            gpr_next[i] = gpr_reg[i];
        end
        isp_next = isp_reg;
        pc_next  = pc_reg;
        sr_next  = sr_reg;
        vbr_next = vbr_reg;
        cfg_next = cfg_reg;
        st_next  = st_reg;
        rd_next  = 32'h0000_0000;
        rv_next  = 1'b0;
        er_next  = 1'b0;
        priv_fault = 1'b0;
        unique case (st_reg)
            cpm_pkg::CPM_FETCH_SP: begin
                if (vec_ack) begin
                    isp_next = vec_data;
                    st_next  = cpm_pkg::CPM_FETCH_PC;
                end
            end
            cpm_pkg::CPM_FETCH_PC: begin
                if (vec_ack) begin
                    pc_next = vec_data;
                    st_next = cpm_pkg::CPM_RUN;
                end
            end
            cpm_pkg::CPM_RUN: begin
                // core side first, debug writes last so the debugger wins
                if (gpr_we) begin
                    gpr_next[gpr_waddr] = gpr_wdata;
                end
                if (pc_we) begin
                    pc_next = pc_wdata;
                end
                if (flags_we) begin
                    if (arith_op) begin
                        sr_next[cpm_pkg::BIT_EXT] = carry_out;
                    end
                    sr_next[cpm_pkg::BIT_NEG]   = result[31];
                    sr_next[cpm_pkg::BIT_ZERO]  = (result == 32'h0000_0000);
                    sr_next[cpm_pkg::BIT_OVF]   = overflow;
                    sr_next[cpm_pkg::BIT_CARRY] = carry_out;
                end
                if (status_we) begin
                    // user code reaches only the flags
                    if (supv) begin
                        sw = status_wdata & cpm_pkg::STATUS_MASK;
                    end else begin
                        sw = (sr_reg & ~cpm_pkg::FLAGS_MASK)
                           | (status_wdata & cpm_pkg::FLAGS_MASK);
                    end
                    // swap stack pointers when the privilege flag flips
                    if (sw[cpm_pkg::BIT_PRIV] != sr_reg[cpm_pkg::BIT_PRIV]) begin
                        gpr_next[15] = isp_reg;
                        isp_next     = gpr_reg[15];
                    end
                    sr_next = sw;
                end
                if (irq_take) begin
                    sr_next[cpm_pkg::BIT_MASTER] = 1'b0;
                end
                if (ctl_we) begin
                    if (!supv) begin
                        priv_fault = 1'b1;
                    end else if (ctl_idx == cpm_pkg::CTL_IDX_VBASE) begin
                        vbr_next = ctl_wdata & cpm_pkg::VBASE_MASK;
                    end else if (ctl_idx == cpm_pkg::CTL_IDX_CFG) begin
                        cfg_next = ctl_wdata;
                    end
                end
                if (usp_to_reg || reg_to_usp) begin
                    // user stack is the inactive one in supervisor mode
                    if (!supv) begin
                        priv_fault = 1'b1;
                    end else if (usp_to_reg) begin
                        gpr_next[usp_reg] = isp_reg;
                    end else begin
                        isp_next = gpr_reg[usp_reg];
                    end
                end
                if (dbg_rd) begin
                    rv_next = 1'b1;
                    rd_next = gpr_reg[dbg_idx];
                end else if (dbg_wr) begin
                    gpr_next[dbg_idx] = dbg_wdata;
                end else if (dbg_valid) begin
                    unique case (dbg_cmd)
                        cpm_pkg::DBG_RD_PC: begin
                            rv_next = 1'b1;
                            rd_next = pc_reg;
                        end
                        cpm_pkg::DBG_WR_PC: pc_next = dbg_wdata;
                        cpm_pkg::DBG_RD_STATUS: begin
                            rv_next = 1'b1;
                            rd_next = {16'h0000, sr_reg};
                        end
                        cpm_pkg::DBG_WR_STATUS: begin
                            sr_next = dbg_wdata[15:0] & cpm_pkg::STATUS_MASK;
                        end
                        cpm_pkg::DBG_RD_ISP: begin
                            rv_next = 1'b1;
                            rd_next = isp_reg;
                        end
                        cpm_pkg::DBG_WR_ISP: isp_next = dbg_wdata;
                        cpm_pkg::DBG_RD_VBASE: begin
                            rv_next = 1'b1;
                            rd_next = vbr_reg;
                        end
                        cpm_pkg::DBG_WR_VBASE: begin
                            vbr_next = dbg_wdata & cpm_pkg::VBASE_MASK;
                        end
                        cpm_pkg::DBG_RD_CFG: begin
                            rv_next = 1'b1;
                            rd_next = cfg_reg;
                        end
                        cpm_pkg::DBG_WR_CFG: cfg_next = dbg_wdata;
                        default: er_next = 1'b1;
                    endcase
                end
            end
            default: st_next = cpm_pkg::CPM_FETCH_SP;
        endcase
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    // undefined registers are cleared anyway to keep simulation tidy
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            for (int i = 0; i < 16; i++) begin
                gpr_reg[i] <= 32'h0000_0000;
            end
            isp_reg <= 32'h0000_0000;
            pc_reg  <= 32'h0000_0000;
            sr_reg  <= cpm_pkg::STATUS_RESET;
            vbr_reg <= 32'h0000_0000;
            cfg_reg <= cpm_pkg::CFG_RESET;
            rd_reg  <= 32'h0000_0000;
            rv_reg  <= 1'b0;
            er_reg  <= 1'b0;
            st_reg  <= cpm_pkg::CPM_FETCH_SP;
        end else begin
            for (int i = 0; i < 16; i++) begin
                gpr_reg[i] <= gpr_next[i];
            end
            // configuration words enter on the first fetch, not at reset
            if (st_reg == cpm_pkg::CPM_FETCH_SP) begin
                gpr_reg[0] <= HW_CFG0;
                gpr_reg[1] <= HW_CFG1;
            end
            isp_reg <= isp_next;
            pc_reg  <= pc_next;
            sr_reg  <= sr_next;
            vbr_reg <= vbr_next;
            cfg_reg <= cfg_next;
            rd_reg  <= rd_next;
            rv_reg  <= rv_next;
            er_reg  <= er_next;
            st_reg  <= st_next;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign vec_req   = (st_reg != cpm_pkg::CPM_RUN);
    assign vec_addr  = (st_reg == cpm_pkg::CPM_FETCH_PC) ? cpm_pkg::RST_VEC_PC
                                                         : cpm_pkg::RST_VEC_SP;
    assign core_ready         = (st_reg == cpm_pkg::CPM_RUN);
    assign dbg_rdata          = rd_reg;
    assign dbg_rvalid         = rv_reg;
    assign dbg_err            = er_reg;
    assign gpr_rdata          = gpr_reg[gpr_raddr];
    assign program_counter    = pc_reg;
    assign status_word        = sr_reg;
    assign vector_table_base  = vbr_reg;
    assign core_configuration = cfg_reg;
    assign trace_req          = sr_reg[cpm_pkg::BIT_TRACE];
    assign irq_pending = irq_edge7 || (irq_level > sr_reg[10:8]);
    assign vec_fetch_addr = vbr_reg + vec_disp;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    AST_RESET_SR: assert property (@(posedge ref_clk)
        $rose(arst_n) |-> sr_reg[15:8] == 8'h27)
        else $error("status word reset value wrong");
    AST_SP_FETCH: assert property (@(posedge ref_clk) disable iff (!arst_n)
        (st_reg == cpm_pkg::CPM_FETCH_SP && vec_ack) |=> isp_reg == $past(vec_data))
        else $error("inactive stack not loaded from vector");
    AST_PC_FETCH: assert property (@(posedge ref_clk) disable iff (!arst_n)
        (st_reg == cpm_pkg::CPM_FETCH_PC && vec_ack) |=> pc_reg == $past(vec_data)
        && core_ready)
        else $error("program counter not loaded from vector");
    AST_VBASE_ZERO: assert property (@(posedge ref_clk) disable iff (!arst_n)
        (vbr_reg & ~cpm_pkg::VBASE_MASK) == 32'h0000_0000)
        else $error("vector base fixed bits set");
    AST_RSVD_ZERO: assert property (@(posedge ref_clk) disable iff (!arst_n)
        (sr_reg & ~cpm_pkg::STATUS_MASK) == 16'h0000)
        else $error("reserved status bits set");
    AST_USER_SYS: assert property (@(posedge ref_clk) disable iff (!arst_n)
        (core_ready && !supv && status_we && !dbg_valid && !irq_take)
        |=> sr_reg[15:8] == $past(sr_reg[15:8]))
        else $error("user code changed system byte");
    AST_IRQ_M: assert property (@(posedge ref_clk) disable iff (!arst_n)
        (core_ready && irq_take && !(dbg_valid && dbg_cmd == cpm_pkg::DBG_WR_STATUS))
        |=> !sr_reg[cpm_pkg::BIT_MASTER])
        else $error("interrupt left master flag set");
    AST_SP_SWAP: assert property (@(posedge ref_clk) disable iff (!arst_n)
        (core_ready && status_we && supv && !status_wdata[cpm_pkg::BIT_PRIV]
         && !dbg_valid && !gpr_we && !usp_to_reg && !reg_to_usp)
        |=> gpr_reg[15] == $past(isp_reg) && isp_reg == $past(gpr_reg[15]))
        else $error("stack pointers not swapped");
    AST_DBG_RD: assert property (@(posedge ref_clk) disable iff (!arst_n)
        (core_ready && dbg_valid && dbg_cmd == cpm_pkg::DBG_RD_PC)
        |=> dbg_rvalid && dbg_rdata == $past(pc_reg))
        else $error("debug pc read wrong");
    AST_NMI: assert property (@(posedge ref_clk) disable iff (!arst_n)
        irq_edge7 |-> irq_pending)
        else $error("level seven masked");

    // ------------------------------------------------------------
    // core port, privilege and boot configuration checks
    // ------------------------------------------------------------
    // core write path, excluding cycles where a debug write or swap may win
    AST_GPR_WR: assert property (@(posedge ref_clk) disable iff (!arst_n)
        (core_ready && gpr_we && !dbg_valid && !status_we && !usp_to_reg)
        |=> gpr_reg[$past(gpr_waddr)] == $past(gpr_wdata))
        else $error("core register write lost");
    // user code must not reach supervisor control state
    AST_USER_CTL: assert property (@(posedge ref_clk) disable iff (!arst_n)
        (core_ready && !supv && ctl_we) |-> priv_fault)
        else $error("user control move not faulted");
    AST_CTL_HOLD: assert property (@(posedge ref_clk) disable iff (!arst_n)
        (core_ready && !supv && ctl_we && !dbg_valid)
        |=> vbr_reg == $past(vbr_reg) && cfg_reg == $past(cfg_reg))
        else $error("user control move changed a register");
    // configuration words must be in place before the core runs
    AST_CFG_BOOT: assert property (@(posedge ref_clk) disable iff (!arst_n)
        (st_reg == cpm_pkg::CPM_FETCH_SP)
        |=> gpr_reg[0] == HW_CFG0 && gpr_reg[1] == HW_CFG1)
        else $error("configuration words not loaded");
    AST_USP_FAULT: assert property (@(posedge ref_clk) disable iff (!arst_n)
        (core_ready && !supv && (usp_to_reg || reg_to_usp)) |-> priv_fault)
        else $error("user stack move not faulted");

    COV_FAULT: cover property (@(posedge ref_clk) disable iff (!arst_n)
        core_ready && priv_fault);
    COV_NMI: cover property (@(posedge ref_clk) disable iff (!arst_n)
        core_ready && irq_edge7);
    COV_BOOT: cover property (@(posedge ref_clk) disable iff (!arst_n) $rose(core_ready));
    COV_USER: cover property (@(posedge ref_clk) disable iff (!arst_n) $fell(supv));
    COV_DBGW: cover property (@(posedge ref_clk) disable iff (!arst_n)
        core_ready && dbg_wr);
endmodule : cpm_regfile
`default_nettype wire

// [sim/cpm_regfile_tb_top.sv]
// testbench: debug command and core port checks of the register file
`default_nettype none
module cpm_regfile_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [31:0] CFG0 = 32'hA5A5_0001; // arbitrary value
    localparam logic [31:0] CFG1 = 32'h0000_0E07; // arbitrary value
    localparam logic [31:0] SPV  = 32'h0080_1FF0;
    localparam logic [31:0] PCV  = 32'h0000_0410;
    logic        ref_clk = 1'b0;
    logic        arst_n = 1'b0;
    logic        vec_req, vec_ack, core_ready, dbg_rvalid, dbg_err, priv_fault;
    logic        irq_pending, trace_req;
    logic [31:0] vec_addr, vec_data, dbg_rdata, gpr_rdata, program_counter;
    logic [31:0] vec_fetch_addr, vector_table_base, core_configuration;
    logic [15:0] status_word;
    logic        dbg_valid, gpr_we, pc_we, status_we, ctl_we, usp_to_reg, reg_to_usp;
    logic        flags_we, carry_out, overflow, irq_take, irq_edge7;
    logic [7:0]  dbg_cmd;
    logic [3:0]  gpr_raddr, usp_reg;
    logic [11:0] ctl_idx;
    logic [2:0]  irq_level;
    logic [31:0] dbg_wdata, ctl_wdata, result, vec_disp, rd;
    logic        rv, er, pf;
    int          fail_count = 0;
    int          samples_checked = 0;
    int          n;

    always #2 ref_clk = ~ref_clk;

    cpm_vec_mem u_cpm_vec_mem (.ref_clk(ref_clk), .vec_req(vec_req), .vec_addr(vec_addr),
        .vec_ack(vec_ack), .vec_data(vec_data));
    cpm_regfile #(.HW_CFG0(CFG0), .HW_CFG1(CFG1)) u_cpm_regfile (
        .ref_clk(ref_clk), .arst_n(arst_n), .vec_req(vec_req), .vec_addr(vec_addr),
        .vec_ack(vec_ack), .vec_data(vec_data), .core_ready(core_ready),
        .dbg_valid(dbg_valid), .dbg_cmd(dbg_cmd), .dbg_wdata(dbg_wdata),
        .dbg_rdata(dbg_rdata), .dbg_rvalid(dbg_rvalid), .dbg_err(dbg_err),
        .gpr_we(gpr_we), .gpr_waddr(usp_reg), .gpr_wdata(ctl_wdata), .gpr_raddr(gpr_raddr),
        .gpr_rdata(gpr_rdata), .pc_we(pc_we), .pc_wdata(ctl_wdata),
        .program_counter(program_counter), .status_we(status_we),
        .status_wdata(ctl_wdata[15:0]), .status_word(status_word), .ctl_we(ctl_we),
        .ctl_idx(ctl_idx), .ctl_wdata(ctl_wdata), .usp_to_reg(usp_to_reg),
        .reg_to_usp(reg_to_usp), .usp_reg(usp_reg), .priv_fault(priv_fault),
        .flags_we(flags_we), .arith_op(1'b1), .result(result), .carry_out(carry_out),
        .overflow(overflow), .irq_take(irq_take), .irq_level(irq_level),
        .irq_edge7(irq_edge7), .irq_pending(irq_pending), .trace_req(trace_req),
        .vec_disp(vec_disp), .vec_fetch_addr(vec_fetch_addr),
        .vector_table_base(vector_table_base), .core_configuration(core_configuration));

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic final_report;
        if (fail_count == 0 && samples_checked > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    // one debug command; answer sampled in the cycle after the taking edge
    task automatic dbg(input logic [7:0] cmd, input logic [31:0] wd);
        @(negedge ref_clk);
        dbg_valid = 1'b1;
        dbg_cmd = cmd;
        dbg_wdata = wd;
        @(negedge ref_clk);
        dbg_valid = 1'b0;
        rd = dbg_rdata;
        rv = dbg_rvalid;
        er = dbg_err;
    endtask

    // one core-side strobe: 0 status, 1 control move, 2 to user stack,
    // 3 flags, 4 interrupt taken, 5 from user stack, 6 core register, 7 pc
    task automatic cw(input int k, input logic [11:0] idx, input logic [31:0] d);
        @(negedge ref_clk);
        ctl_idx = idx;
        ctl_wdata = d;
        usp_reg = idx[3:0];
        result = d;
        carry_out = idx[1];
        overflow = idx[0];
        case (k)
            0: status_we = 1'b1;
            1: ctl_we = 1'b1;
            2: reg_to_usp = 1'b1;
            3: flags_we = 1'b1;
            4: irq_take = 1'b1;
            6: gpr_we = 1'b1;
            7: pc_we = 1'b1;
            default: usp_to_reg = 1'b1;
        endcase
        #1 pf = priv_fault;
        @(negedge ref_clk);
        {status_we, ctl_we, reg_to_usp, flags_we, irq_take, usp_to_reg, gpr_we, pc_we} = 8'h00;
    endtask

    initial begin
        {dbg_valid, gpr_we, pc_we, status_we, ctl_we, usp_to_reg, reg_to_usp} = 7'h00;
        {flags_we, carry_out, overflow, irq_take, irq_edge7} = 5'h00;
        {dbg_cmd, gpr_raddr, usp_reg, ctl_idx, irq_level} = 31'h0;
        {dbg_wdata, ctl_wdata, result, vec_disp} = 128'h0;
        repeat (12) @(posedge ref_clk);
        @(negedge ref_clk);
        arst_n = 1'b1;
        for (n = 0; n < 60 && core_ready !== 1'b1; n++) @(negedge ref_clk);
        check({31'h0, core_ready}, 32'h1);
        check({16'h0, status_word}, 32'h0000_2700);
        dbg(8'hEF, 32'h0); check(rd, PCV);
        dbg(8'hE0, 32'h0); check(rd, SPV);
        dbg(8'h60, 32'h0); check(rd, CFG0);
        dbg(8'h61, 32'h0); check(rd, CFG1);
        dbg(8'hCE, 32'h0000_2700);
        // all sixteen registers written first so aliasing shows on readback
        for (n = 0; n < 16; n++) dbg(8'h40 + n[7:0], 32'hF00D_0000 + n * 32'h0101);
        for (n = 0; n < 16; n++) begin
            dbg(8'h60 + n[7:0], 32'h0); check(rd, 32'hF00D_0000 + n * 32'h0101);
            gpr_raddr = n[3:0];
            #1 check(gpr_rdata, 32'hF00D_0000 + n * 32'h0101);
        end
        dbg(8'hCF, 32'h0000_8AC0); check(program_counter, 32'h0000_8AC0);
        dbg(8'hEF, 32'h0); check({rv, rd[30:0]}, 32'h8000_8AC0);
        dbg(8'hCE, 32'hFFFF_FFFF); dbg(8'hEE, 32'h0); check(rd, 32'h0000_B71F);
        dbg(8'hC1, 32'hFFFF_FFFF); dbg(8'hE1, 32'h0); check(rd, 32'h00F0_0000);
        dbg(8'hC2, 32'hFFFF_FFFF); dbg(8'hE2, 32'h0); check(rd, 32'hFFFF_FFFF);
        dbg(8'hFF, 32'h0); check({30'h0, er, rv}, 32'h2);
        dbg(8'hCE, 32'h0000_2700); check({16'h0, status_word}, 32'h2700);
        cw(1, 12'h801, 32'h1234_5678); check(vector_table_base, 32'h0030_0000);
        vec_disp = 32'h0000_0100;
        #1 check(vec_fetch_addr, 32'h0030_0100);
        cw(1, 12'h802, 32'hCAFE_F00D); check(core_configuration, 32'hCAFE_F00D);
        // stacks: the debugger places the two values, clearing the privilege bit swaps them
        dbg(8'h4F, 32'h0000_5550); dbg(8'hC0, 32'h0000_7770);
        cw(0, 12'h0, 32'h0); gpr_raddr = 4'hF;
        #1 check(gpr_rdata, 32'h0000_7770);
        dbg(8'hE0, 32'h0); check(rd, 32'h0000_5550);
        cw(0, 12'h0, 32'h0000_FFFF); check({16'h0, status_word}, 32'h001F);
        cw(1, 12'h801, 32'h0050_0000); check({31'h0, pf}, 32'h1);
        check(vector_table_base, 32'h0030_0000);
        cw(2, 12'h001, 32'h0); check({31'h0, pf}, 32'h1);
        dbg(8'hCE, 32'h0000_2000);
        cw(2, 12'h001, 32'h0); dbg(8'hE0, 32'h0); check(rd, 32'hF00D_0101);
        cw(5, 12'h003, 32'h0); gpr_raddr = 4'h3;
        #1 check(gpr_rdata, 32'hF00D_0101);
        cw(3, 12'h003, 32'h0); check({16'h0, status_word}, 32'h2017);
        cw(3, 12'h000, 32'h8000_0000); check({16'h0, status_word}, 32'h2008);
        cw(3, 12'h002, 32'h1); check({16'h0, status_word}, 32'h2011);
        dbg(8'hCE, 32'h0000_B300); check({31'h0, trace_req}, 32'h1);
        irq_level = 3'h3;
        #1 check({31'h0, irq_pending}, 32'h0);
        irq_level = 3'h4;
        #1 check({31'h0, irq_pending}, 32'h1);
        cw(4, 12'h0, 32'h0); check({16'h0, status_word}, 32'hA300);
        dbg(8'hCE, 32'h0000_2700); check({31'h0, trace_req}, 32'h0);
        irq_level = 3'h7;
        irq_edge7 = 1'b1;
        #1 check({31'h0, irq_pending}, 32'h1);
        cw(6, 12'h005, 32'h1357_9BDF); gpr_raddr = 4'h5;
        #1 check(gpr_rdata, 32'h1357_9BDF);
        cw(7, 12'h000, 32'h0000_0A00); dbg(8'hEF, 32'h0); check(rd, 32'h0000_0A00);
        final_report;
    end

    // the sequence needs well under a thousand cycles
    initial begin
        #20000;
        fail_count++;
        final_report;
    end
endmodule // cpm_regfile_tb_top
`default_nettype wire

// [sim/cpm_vec_mem.sv]
// partner model: boot memory answering the reset vector fetch
`default_nettype none
module cpm_vec_mem #(
    parameter logic [31:0] SP_INIT = 32'h0080_1FF0,
    parameter logic [31:0] PC_INIT = 32'h0000_0410,
    parameter int          WAIT    = 2
) (
    input  wire logic        ref_clk,
    input  wire logic        vec_req,
    input  wire logic [31:0] vec_addr,
    output logic             vec_ack,
    output logic [31:0]      vec_data
);
    timeunit 1ns;
    timeprecision 1ps;
    int          cnt;
    logic [31:0] word;
    // longword at 0x00_0004 is the start address, at 0x00_0000 the stack
    assign word = (vec_addr == 32'h0000_0004) ? PC_INIT : SP_INIT;
    initial begin
        cnt = 0;
        vec_ack = 1'b0;
        vec_data = ~SP_INIT;
    end
    // slow memory: waits WAIT cycles; data toggles when not acknowledged
    always @(negedge ref_clk) begin
        if (vec_req && !vec_ack && cnt >= WAIT) begin
            vec_ack <= 1'b1;
            vec_data <= word;
            cnt <= 0;
        end else begin
            vec_ack <= 1'b0;
            vec_data <= ~vec_data;
            cnt <= vec_req ? cnt + 1 : 0;
        end
    end
endmodule // cpm_vec_mem
`default_nettype wire
